// [rtl/smf_fault_latch.sv]
`timescale 1ns/1ps
`default_nettype none
module smf_fault_latch #(
   parameter logic [23:0] CONF_CYC = 24'(smf_pkg::CONF_CYC),
   parameter logic [23:0] RED_CYC  = 24'(smf_pkg::RED_CYC)
) (
   input  wire logic                          CORE_CLK_IN,
   input  wire logic                          RST_IN,
   input  wire logic                          CE_IN,
   input  wire smf_pkg::smf_sense_t           SENSE_IN,
   input  wire smf_pkg::smf_ctrl_t            CTRL_IN,
   input  wire smf_pkg::smf_variant_t         VARIANT_IN,
   input  wire logic [smf_pkg::NUM_PAIR-1:0]  COMPAT_IN,
   output logic                               RELAY_FAULT_OUT,
   output logic                               CONF_IND_OUT,
   output logic                               RED_IND_OUT,
   output logic                               VOLT_IND_OUT,
   output logic [smf_pkg::NUM_CH-1:0]         CH_IND_OUT
);
   localparam int N = smf_pkg::NUM_CH;

   // Bit position of pair (i,j), i<j, in the programming vector
   function automatic int pair_idx(input int i, input int j);
      pair_idx = i * N - (i * (i + 1)) / 2 + (j - i - 1);
   endfunction : pair_idx

   // Number of channels present in a variant
   function automatic int var_ch(input smf_pkg::smf_variant_t v);
      case (v)
         smf_pkg::SMF_VAR_3:  var_ch = 3;
         smf_pkg::SMF_VAR_6:  var_ch = 6;
         smf_pkg::SMF_VAR_12: var_ch = 12;
         default:             var_ch = 18;
      endcase
   endfunction : var_ch

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers: a level counts once stages two and three agree
   logic [smf_pkg::SYNC_W-1:0] s1, s2, s3, filt;
   smf_pkg::smf_sense_t        sns;
   smf_pkg::smf_ctrl_t         ctl;

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '0;
      end else if (CE_IN) begin
         s1   <= {SENSE_IN, CTRL_IN};
         s2   <= s1;
         s3   <= s2;
         filt <= (s2 & s3) | (filt & (s2 | s3));
      end
   end

   assign sns = filt[smf_pkg::SYNC_W-1:8];
   assign ctl = filt[7:0];

   logic rst_any;
   logic volt_fault;
   assign rst_any = ctl.man_rst | ctl.ext_rst;
   // Internal supply loss counts as a voltage failure; inhibit is low-true
   assign volt_fault = !ctl.pwr_ok
                     | (ctl.mon24_inh_n & !(ctl.mon24_a & ctl.mon24_b))
                     | ctl.ctrl_vmon_n;

   ////////////////////////////////////////////////////////////////////////
   // Program capture: straps are static, so they are read once after reset
   logic                 loaded;
   smf_pkg::smf_variant_t var_q;
   logic [N-1:0]         compat [N];

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         loaded <= smf_pkg::RST_VAL;
         var_q  <= smf_pkg::SMF_VAR_3;
         for (int i = 0; i < N; i++) begin
            compat[i] <= '0;
         end
      end else if (CE_IN && !loaded) begin
         loaded <= 1'h1;
         var_q  <= VARIANT_IN;
         for (int i = 0; i < N; i++) begin
            for (int j = 0; j < N; j++) begin
               if (VARIANT_IN == smf_pkg::SMF_VAR_3 || i == j) begin
                  compat[i][j] <= 1'h0;
               end else if (i < j) begin
                  compat[i][j] <= COMPAT_IN[pair_idx(i, j)];
               end else begin
                  compat[i][j] <= COMPAT_IN[pair_idx(j, i)];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel activity and conflict detection
   logic [N-1:0] in_rng;
   logic [N-1:0] act;
   logic [N-1:0] none_on;
   logic         conflict;

   always_comb begin
      conflict = 1'h0;
      for (int i = 0; i < N; i++) begin
         in_rng[i]  = loaded && (i < var_ch(var_q));
         act[i]     = in_rng[i] & (sns.grn[i] | sns.yel[i] | sns.walk[i]);
         none_on[i] = in_rng[i] & !(act[i] | sns.red[i]);
      end
      for (int i = 0; i < N; i++) begin
         for (int j = i + 1; j < N; j++) begin
            if (act[i] && act[j] && !compat[i][j]) begin
               conflict = 1'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conflict timer and latch; held clear while any reset source is active
   logic [23:0] conf_cnt;
   logic        conf_trip;

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         conf_cnt  <= '0;
         conf_trip <= 1'h0;
      end else if (CE_IN) begin
         if (rst_any) begin
            conf_cnt  <= '0;
            conf_trip <= 1'h0;
         end else if (!conflict) begin
            conf_cnt <= '0;
         end else if (conf_cnt == CONF_CYC - 24'h1) begin
            conf_trip <= 1'h1;
         end else begin
            conf_cnt <= conf_cnt + 24'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Missing-red timers, one per channel, gated by the red enable
   logic [N-1:0] red_hit;
   logic         red_trip;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_red
         logic [23:0] cnt;
         assign red_hit[g] = (cnt == RED_CYC - 24'h1) & none_on[g];
         always_ff @(posedge CORE_CLK_IN) begin
            if (RST_IN) begin
               cnt <= '0;
            end else if (CE_IN) begin
               if (rst_any || !ctl.red_en || !none_on[g] || red_hit[g]) begin
                  cnt <= '0;
               end else begin
                  cnt <= cnt + 24'h1;
               end
            end
         end
      end
   endgenerate

   // Power loss leaves the trip in place; only a reset source clears it
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         red_trip <= 1'h0;
      end else if (CE_IN) begin
         if (rst_any) begin
            red_trip <= 1'h0;
         end else if (ctl.red_en && |red_hit) begin
            red_trip <= 1'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel indicators: live until the conflict trip, then frozen until supply loss or a reset source
   logic frozen;

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         frozen     <= 1'h0;
         CH_IND_OUT <= '0;
      end else if (CE_IN) begin
         if (rst_any || !ctl.pwr_ok) begin
            frozen <= 1'h0;
         end else if (!conf_trip && conflict
                      && conf_cnt == CONF_CYC - 24'h1) begin
            frozen <= 1'h1; // only on the trip edge, not re-armed
         end
         if (!frozen) begin
            CH_IND_OUT <= act;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Relay drive and fault indicators, all from flip-flops
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         RELAY_FAULT_OUT <= 1'h0;
         CONF_IND_OUT    <= 1'h0;
         RED_IND_OUT     <= 1'h0;
         VOLT_IND_OUT    <= 1'h0;
      end else if (CE_IN) begin
         RELAY_FAULT_OUT <= !rst_any
                          & (conf_trip | red_trip | volt_fault);
         CONF_IND_OUT    <= conf_trip;
         RED_IND_OUT     <= red_trip;
         VOLT_IND_OUT    <= volt_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);

   property p_rst_hold;
      CE_IN && rst_any |=> !RELAY_FAULT_OUT;
   endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("relay faulted while reset held");
   property p_release;
      CE_IN && $fell(rst_any) && volt_fault |=> RELAY_FAULT_OUT;
   endproperty
   a_release: assert property (p_release)
      else $error("fault not restored after reset release");
   property p_relay_or;
      CE_IN && !rst_any |=>
         RELAY_FAULT_OUT == $past(conf_trip | red_trip | volt_fault);
   endproperty
   a_relay_or: assert property (p_relay_or)
      else $error("relay not the OR of fault sources");
   property p_pwr;
      CE_IN && !rst_any && !ctl.pwr_ok |=> RELAY_FAULT_OUT && VOLT_IND_OUT;
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("supply loss did not fault relay");
   property p_freeze;
      frozen && CE_IN && !rst_any && ctl.pwr_ok |=> $stable(CH_IND_OUT);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("channel indicators moved while frozen");
   property p_latch;
      conf_trip && CE_IN && !rst_any |=> conf_trip && frozen == $past(frozen)
         || !$past(ctl.pwr_ok);
   endproperty
   a_latch: assert property (p_latch)
      else $error("conflict latch lost without reset");
   property p_red_inh;
      !red_trip && !ctl.red_en |=> !red_trip;
   endproperty
   a_red_inh: assert property (p_red_inh)
      else $error("missing red tripped while disabled");
   property p_conf_time;
      $rose(conf_trip) |-> $past(conf_cnt) == CONF_CYC - 24'h1;
   endproperty
   a_conf_time: assert property (p_conf_time)
      else $error("conflict trip before full overlap time");

   property p_type3;
      loaded && var_q == smf_pkg::SMF_VAR_3 |-> compat[0][1] == 1'h0
         && compat[1][2] == 1'h0 && compat[0][2] == 1'h0;
   endproperty
   a_type3: assert property (p_type3)
      else $error("three-channel pair marked compatible");

   c_conf: cover property ($rose(conf_trip));
   c_red: cover property ($rose(red_trip));
   c_volt: cover property ($rose(RELAY_FAULT_OUT) && volt_fault);
endmodule : smf_fault_latch
`default_nettype wire

// [rtl/smf_pkg.sv]
package smf_pkg;
   // Channel count of the largest variant
   localparam int         NUM_CH    = 18;
   localparam int         NUM_PAIR  = NUM_CH * (NUM_CH - 1) / 2;
   // Clock rate and documented trip windows
   localparam int         CLK_HZ    = 10_000_000;
   localparam int         CONF_MS   = 450;
   localparam int         RED_MS    = 1000;
   localparam int         CONF_CYC  = CONF_MS * (CLK_HZ / 1000);
   localparam int         RED_CYC   = RED_MS * (CLK_HZ / 1000);
   localparam int         CNT_W     = 24;
   // Synchroniser width: 4 sense groups plus 8 control levels
   localparam int         SYNC_W    = 4 * NUM_CH + 8;
   localparam logic [0:0] RST_VAL   = 1'h0;

   typedef enum logic [1:0] {
      SMF_VAR_3, SMF_VAR_6, SMF_VAR_12, SMF_VAR_18
   } smf_variant_t;

   // Field sense inputs, one bit per channel
   typedef struct packed {
      logic [NUM_CH-1:0] grn;
      logic [NUM_CH-1:0] yel;
      logic [NUM_CH-1:0] red;
      logic [NUM_CH-1:0] walk;
   } smf_sense_t;

   // Supervision levels
   typedef struct packed {
      logic man_rst;
      logic ext_rst;
      logic red_en;
      logic mon24_a;
      logic mon24_b;
      logic mon24_inh_n;
      logic ctrl_vmon_n;
      logic pwr_ok;
   } smf_ctrl_t;
endpackage : smf_pkg

// [verif/signal_monitor_fault_latch_test.sv]
`timescale 1ns/1ps
`default_nettype none
module signal_monitor_fault_latch_test;
   localparam logic [23:0] CONF_N = 24'h000014;
   localparam logic [23:0] RED_N  = 24'h000028;
   // Supervision all good: inhibit off, controller ok, supply ok
   localparam logic [7:0]  GOOD   = 8'h1d;
   logic                         clk     = 1'h0;
   logic                         rst     = 1'h1;
   logic                         ce      = 1'h1;
   smf_pkg::smf_ctrl_t           sup     = GOOD;
   smf_pkg::smf_variant_t        var_sel = smf_pkg::SMF_VAR_3;
   logic [smf_pkg::NUM_PAIR-1:0] compat  = '0;
   logic [smf_pkg::NUM_CH-1:0]   go      = '0;
   logic [smf_pkg::NUM_CH-1:0]   dark    = '0;
   smf_pkg::smf_sense_t          sense;
   logic                         relay;
   logic                         conf;
   logic                         red;
   logic                         volt;
   logic [smf_pkg::NUM_CH-1:0]   ch_ind;
   int                           error_cnt = 0;
   int                           tests_run = 0;
   int                           cyc       = 0;
   ////////////////////////////////////////////////////////////////////////
   // Clock at 10 MHz; short trip counts keep the run brief
   always #50 clk = ~clk;
   smf_field_model u_smf_field_model (.go_in(go), .dark_in(dark),
      .sense_out(sense));
   smf_fault_latch #(.CONF_CYC(CONF_N), .RED_CYC(RED_N)) u_smf_fault_latch (
      .CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .SENSE_IN(sense),
      .CTRL_IN(sup), .VARIANT_IN(var_sel), .COMPAT_IN(compat),
      .RELAY_FAULT_OUT(relay), .CONF_IND_OUT(conf), .RED_IND_OUT(red),
      .VOLT_IND_OUT(volt), .CH_IND_OUT(ch_ind));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   // Hang guard, several times the roughly 700 cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   // One compare per result kind; case inequality lets no unknown pass
   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk_bit
   task automatic chk_vec(input string n, input logic [17:0] e,
                          input logic [17:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk_vec
   // Inputs move on the falling edge, away from the sampling edge
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   // Straps are only taken after a logic reset, so each variant resets
   task automatic restart(input smf_pkg::smf_variant_t v,
                          input logic [152:0] c);
      rst = 1'h1;
      var_sel = v;
      compat = c;
      tick(16);
      rst = 1'h0;
      tick(10);
   endtask : restart
   // Manual or external reset held, then released with no fault left
   task automatic pulse_rst(input bit manual);
      if (manual) begin
         sup.man_rst = 1'h1;
      end else begin
         sup.ext_rst = 1'h1;
      end
      tick(8);
      chk_bit("relay in reset", 1'h0, relay);
      sup.man_rst = 1'h0;
      sup.ext_rst = 1'h0;
      tick(8);
      chk_bit("relay released", 1'h0, relay);
   endtask : pulse_rst
   ////////////////////////////////////////////////////////////////////////
   // Three channels: all pairs clash whatever the program says
   task automatic t_conflict();
      restart(smf_pkg::SMF_VAR_3, '1);
      chk_bit("relay idle", 1'h0, relay);
      // Overlap kept well under the scaled no-trip bound
      go = 18'h00003;
      tick(6);
      chk_vec("ch ind", 18'h00003, ch_ind);
      go = 18'h00000;
      tick(8);
      chk_bit("short overlap", 1'h0, conf);
      go = 18'h00009;
      tick(30);
      chk_bit("ch beyond variant", 1'h0, conf);
      go = 18'h00003;
      tick(30);
      chk_bit("conf ind", 1'h1, conf);
      chk_bit("relay trip", 1'h1, relay);
      go = 18'h00004;
      tick(10);
      chk_vec("ch frozen", 18'h00003, ch_ind);
      sup.pwr_ok = 1'h0;
      tick(10);
      sup.pwr_ok = 1'h1;
      tick(10);
      chk_bit("conf after power", 1'h1, conf);
      // Power loss releases the freeze, so the live channel shows again
      chk_vec("ch after power", 18'h00004, ch_ind);
      go = 18'h00000;
      pulse_rst(1'h1);
      chk_bit("conf cleared", 1'h0, conf);
   endtask : t_conflict
   // Programmed pair 0-1 compatible, others clash; yellow counts too
   task automatic t_compat();
      restart(smf_pkg::SMF_VAR_12, 153'h1);
      go = 18'h00003;
      tick(30);
      chk_bit("compatible pair", 1'h0, conf);
      go = 18'h00041;
      tick(30);
      chk_bit("unprogrammed pair", 1'h1, conf);
      chk_vec("ch yellow", 18'h00041, ch_ind);
      go = 18'h00000;
      pulse_rst(1'h0);
      chk_bit("conf ext cleared", 1'h0, conf);
      // Six channels: channel 6 lies outside, so its yellow is ignored
      restart(smf_pkg::SMF_VAR_6, '0);
      go = 18'h00041;
      tick(30);
      chk_bit("ch beyond six", 1'h0, conf);
      chk_vec("ch six range", 18'h00001, ch_ind);
      go = 18'h00000;
      restart(smf_pkg::SMF_VAR_18, '0);
      go = 18'h01000;
      tick(10);
      chk_vec("ch walk", 18'h01000, ch_ind);
      go = 18'h00000;
   endtask : t_compat
   // Each voltage fault trips and clears itself; inhibit masks 24 V
   task automatic t_volt();
      restart(smf_pkg::SMF_VAR_3, '0);
      // Clock enable low freezes the synchronisers, so no fault shows yet
      ce = 1'h0;
      sup.pwr_ok = 1'h0;
      tick(10);
      chk_bit("volt while frozen", 1'h0, volt);
      ce = 1'h1;
      tick(10);
      chk_bit("volt after enable", 1'h1, volt);
      for (int k = 0; k < 5; k++) begin
         sup = GOOD;
         case (k)
            0: sup.pwr_ok = 1'h0;
            1: sup.mon24_a = 1'h0;
            2: sup.mon24_b = 1'h0;
            3: sup.ctrl_vmon_n = 1'h1;
            default: begin
               sup.mon24_a = 1'h0;
               sup.mon24_inh_n = 1'h0;
            end
         endcase
         tick(10);
         chk_bit("volt ind", k < 4, volt);
         chk_bit("volt relay", k < 4, relay);
         sup = GOOD;
         tick(10);
         chk_bit("volt self clear", 1'h0, relay);
      end
      sup.pwr_ok = 1'h0;
      sup.ext_rst = 1'h1;
      tick(10);
      chk_bit("reset over volt", 1'h0, relay);
      sup.ext_rst = 1'h0;
      tick(10);
      chk_bit("fault on release", 1'h1, relay);
      sup = GOOD;
      tick(10);
   endtask : t_volt
   // Dark channel trips only with red enable and only when long enough
   task automatic t_red();
      dark = 18'h00001;
      tick(60);
      chk_bit("red inhibited", 1'h0, red);
      dark = 18'h00000;
      sup.red_en = 1'h1;
      tick(8);
      dark = 18'h00001;
      tick(20);
      dark = 18'h00000;
      tick(8);
      chk_bit("short dark", 1'h0, red);
      dark = 18'h00001;
      tick(50);
      chk_bit("red ind", 1'h1, red);
      chk_bit("red relay", 1'h1, relay);
      dark = 18'h00000;
      // A supply dip must not lose the missing-red trip
      sup.pwr_ok = 1'h0;
      tick(10);
      sup.pwr_ok = 1'h1;
      tick(10);
      chk_bit("red after power", 1'h1, red);
      pulse_rst(1'h1);
      chk_bit("red cleared", 1'h0, red);
      sup.red_en = 1'h0;
   endtask : t_red
   ////////////////////////////////////////////////////////////////////////
   // Reset starts high and the first restart holds it for 16 cycles
   initial begin
      t_conflict();
      t_compat();
      t_volt();
      t_red();
      print_verdict();
   end
endmodule : signal_monitor_fault_latch_test
`default_nettype wire

// [verif/smf_field_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Cabinet field side: lamp drive of each channel as the monitor senses it
module smf_field_model (
   input  wire logic [smf_pkg::NUM_CH-1:0] go_in,
   input  wire logic [smf_pkg::NUM_CH-1:0] dark_in,
   output var  smf_pkg::smf_sense_t        sense_out
);
   // Go shows as green on 0-5, yellow on 6-11, walk on 12-17
   // A channel that is not on go shows red unless its lamps are dark
   always_comb begin
      sense_out.grn  = go_in & 18'h0003f;
      sense_out.yel  = go_in & 18'h00fc0;
      sense_out.walk = go_in & 18'h3f000;
      sense_out.red  = ~go_in & ~dark_in;
   end
endmodule : smf_field_model
`default_nettype wire
